// ==== core/rsr_defs.svh ====
// Offsets, field positions, reset values and timing constants of the radio setup registers.
// How it works
// RL1 - Address width code 01/10/11 gives 3/4/5 bytes; code 00 is illegal.
// RL2 - One address width serves every receive pipe and the transmit address.
// RL3 - Below five bytes only the low address bytes are used; upper ignored.
// RL4 - Retransmit delay is (code+1) times 250 us, end to next start; the timer here runs from ack_fail instead.
// RL5 - Retransmit count zero disables; else up to count retries on failed ack.
// RL6 - Seven-bit channel field selects the radio channel; resets to channel 2.
// RL7 - Continuous carrier bit set makes the radio transmit a steady carrier.
// RL8 - PLL lock force bit is for test only; keep clear normally.
// RL9 - Low and high rate bits pick 1M, 2M, 250k; high ignored when low set.
// RL10 - Output power field picks -18, -12, -6 or 0 dBm; resets to 0 dBm.
// RL11 - Registers are reached only by SPI read and write register commands.
// RL12 - Any write to the channel register clears the lost packet counter.
// RL13 - Host writes zero to reserved bits; device reads them back as zero.
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RSR_OFS_AW 5'h03
`define RSR_OFS_RETR 5'h04
`define RSR_OFS_CH 5'h05
`define RSR_OFS_RF 5'h06

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSR_AW_LSB 0
`define RSR_DELAY_LSB 4
`define RSR_COUNT_LSB 0
`define RSR_CARRIER_BIT 7
`define RSR_LOWRATE_BIT 5
`define RSR_PLLFORCE_BIT 4
`define RSR_HIGHRATE_BIT 3
`define RSR_POWER_LSB 1

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define RSR_RST_AW 8'h03
`define RSR_RST_RETR 8'h03
`define RSR_RST_CH 8'h02
`define RSR_RST_RF 8'h0E
`define RSR_MASK_AW 8'h03
`define RSR_MASK_RETR 8'hFF
`define RSR_MASK_CH 8'h7F
`define RSR_MASK_RF 8'hBE

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RSR_CLK_HZ 40000000
`define RSR_DELAY_STEP_US 250
`define RSR_DELAY_STEP_CYC ((`RSR_CLK_HZ / 1000000) * `RSR_DELAY_STEP_US)

`endif

// ==== core/rsr_pkg.sv ====
// Types shared by the radio setup register block.
`default_nettype none
package rsr_pkg;
  typedef enum logic [1:0] {
    RSR_RATE_1M = 2'h0,
    RSR_RATE_2M = 2'h1,
    RSR_RATE_250K = 2'h2,
    RSR_RATE_RSVD = 2'h3
  } rsr_rate_type;

  typedef enum logic [2:0] {
    RSR_ST_IDLE = 3'h1,
    RSR_ST_WAIT = 3'h2,
    RSR_ST_DONE = 3'h4
  } rsr_delay_state_type;
endpackage
`default_nettype wire

// ==== core/rsr_delay_timer.sv ====
// Retransmit wait timer: counts (code+1) steps of 250 us after start, which the bank drives on a failed acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"
module rsr_delay_timer #(
  parameter int STEP_CYCLES = `RSR_DELAY_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic [3:0] delay_code,
  // Status
  output logic busy,
  output logic done
);
  rsr_pkg::rsr_delay_state_type state_q, state_d;
  logic [13:0] cyc_q;
  logic [3:0] step_q;
  logic step_end;
  logic [3:0] code_q;

  assign step_end = (cyc_q == 14'(STEP_CYCLES - 1));
  assign busy = (state_q == rsr_pkg::RSR_ST_WAIT);
  assign done = (state_q == rsr_pkg::RSR_ST_DONE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      rsr_pkg::RSR_ST_IDLE: if (start) state_d = rsr_pkg::RSR_ST_WAIT;
      rsr_pkg::RSR_ST_WAIT: if (step_end && step_q == code_q) state_d = rsr_pkg::RSR_ST_DONE; // see RL4
      rsr_pkg::RSR_ST_DONE: state_d = rsr_pkg::RSR_ST_IDLE;
      default: state_d = rsr_pkg::RSR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rsr_pkg::RSR_ST_IDLE;
      cyc_q <= 14'h0000;
      step_q <= 4'h0;
      code_q <= 4'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_q != rsr_pkg::RSR_ST_WAIT) begin
        cyc_q <= 14'h0000;
        step_q <= 4'h0;
        code_q <= delay_code;
      end else if (step_end) begin
        cyc_q <= 14'h0000;
        step_q <= step_q + 4'h1;
      end else begin
        cyc_q <= cyc_q + 14'h0001;
      end
    end
  end
endmodule // rsr_delay_timer
`default_nettype wire

// ==== core/rsr_setup_regs.sv ====
// Radio setup register bank with retransmit sequencing and lost packet counter.
`timescale 1ns/1ps
`default_nettype none
`include "rsr_defs.svh"
module rsr_setup_regs #(
  parameter int STEP_CYCLES = `RSR_DELAY_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port from the SPI command decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Packet engine events
  input wire logic tx_end,
  input wire logic ack_ok,
  input wire logic ack_fail,
  // Address width seen by every pipe and by transmit
  output logic [2:0] addr_bytes,
  output logic [4:0] addr_byte_en,
  output logic addr_width_illegal,
  // Retransmit control
  output logic retry_start,
  output logic retry_wait,
  output logic retry_exhausted,
  output logic [3:0] retry_used,
  output logic [3:0] lost_packet_counter,
  // Radio settings
  output logic [6:0] channel,
  output logic continuous_carrier,
  output logic pll_lock_force,
  output rsr_pkg::rsr_rate_type air_rate,
  output logic [1:0] output_power
);
  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic [7:0] aw_q, retr_q, ch_q, rf_q;
  logic [3:0] used_q, lost_q;
  logic [2:0] bytes_q;
  logic [4:0] en_q;
  logic [7:0] rdata_q;
  logic pending_q;

  // Decoding: the SPI command decoder is the only path to these registers (see RL11).
  wire sel_aw = (reg_addr == `RSR_OFS_AW);
  wire sel_retr = (reg_addr == `RSR_OFS_RETR);
  wire sel_ch = (reg_addr == `RSR_OFS_CH);
  wire sel_rf = (reg_addr == `RSR_OFS_RF);
  wire any_sel = sel_aw | sel_retr | sel_ch | sel_rf;
  wire wr_aw = reg_wr && sel_aw;
  wire wr_retr = reg_wr && sel_retr;
  wire wr_ch = reg_wr && sel_ch;
  wire wr_rf = reg_wr && sel_rf;

  // Reserved bits are never stored, so they always read back zero.
  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    masked = d & m; // see RL13
  endfunction

  wire [7:0] rd_mux = sel_aw ? aw_q :
                      sel_retr ? retr_q :
                      sel_ch ? ch_q :
                      sel_rf ? rf_q : 8'h00;

  // ----------------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------------
  wire [1:0] aw_code = aw_q[`RSR_AW_LSB +: 2];
  wire [3:0] delay_code = retr_q[`RSR_DELAY_LSB +: 4];
  wire [3:0] count_code = retr_q[`RSR_COUNT_LSB +: 4];
  wire low_rate = rf_q[`RSR_LOWRATE_BIT];
  wire high_rate = rf_q[`RSR_HIGHRATE_BIT];

  // Illegal code 00 is held at the widest setting so the engine never sees zero bytes.
  wire [2:0] bytes_d = (aw_code == 2'h1) ? 3'h3 :
                       (aw_code == 2'h2) ? 3'h4 : 3'h5; // see RL1
  // Only the low bytes of each address register take part (see RL3).
  wire [4:0] en_d = (aw_code == 2'h1) ? 5'h07 :
                    (aw_code == 2'h2) ? 5'h0F : 5'h1F;

  // ----------------------------------------------------------------------------
  // Retransmit sequencing
  // ----------------------------------------------------------------------------
  logic tmr_busy, tmr_done;
  wire retry_allowed = (count_code != 4'h0) && (used_q < count_code); // see RL5
  wire fail_now = ack_fail && !pending_q && !tmr_busy;
  wire start_tmr = fail_now && retry_allowed;
  wire give_up = fail_now && !retry_allowed;

  rsr_delay_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(start_tmr),
    .delay_code(delay_code),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // The wait runs from the failed acknowledge, not from tx_end; the timer is armed on ack_fail.
  // A new failure wins over a coincident end, so the retransmission is still awaited.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_q <= 1'b0;
    end else if (clk_en) begin
      if (start_tmr) begin
        pending_q <= 1'b1; // see RL4
      end else if (tx_end) begin
        pending_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_q <= `RSR_RST_AW;
      retr_q <= `RSR_RST_RETR;
      ch_q <= `RSR_RST_CH; // see RL6
      rf_q <= `RSR_RST_RF; // see RL10
    end else if (clk_en) begin
      if (wr_aw) aw_q <= masked(reg_wdata, `RSR_MASK_AW);
      if (wr_retr) retr_q <= masked(reg_wdata, `RSR_MASK_RETR);
      if (wr_ch) ch_q <= masked(reg_wdata, `RSR_MASK_CH);
      if (wr_rf) rf_q <= masked(reg_wdata, `RSR_MASK_RF);
    end
  end

  // ----------------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      used_q <= 4'h0;
      lost_q <= 4'h0;
    end else if (clk_en) begin
      if (ack_ok) begin
        used_q <= 4'h0;
      end else if (tmr_done) begin
        used_q <= used_q + 4'h1; // see RL5
      end else if (give_up) begin
        used_q <= 4'h0;
      end
      // A channel write clears, and wins over a loss in the same cycle.
      if (wr_ch) begin
        lost_q <= 4'h0; // see RL12
      end else if (give_up && lost_q != 4'hF) begin
        lost_q <= lost_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Output and read-data registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bytes_q <= 3'h5;
      en_q <= 5'h1F;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      bytes_q <= bytes_d; // see RL2
      en_q <= en_d; // see RL3
      if (reg_rd) rdata_q <= rd_mux; // see RL13
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = any_sel;
  assign addr_bytes = bytes_q;
  assign addr_byte_en = en_q;
  assign addr_width_illegal = (aw_code == 2'h0);
  assign retry_start = tmr_done;
  assign retry_wait = tmr_busy;
  assign retry_exhausted = give_up;
  assign retry_used = used_q;
  assign lost_packet_counter = lost_q;
  assign channel = ch_q[6:0]; // see RL6
  assign continuous_carrier = rf_q[`RSR_CARRIER_BIT]; // see RL7
  assign pll_lock_force = rf_q[`RSR_PLLFORCE_BIT]; // see RL8
  // High rate bit has no say once the low rate bit is set.
  assign air_rate = low_rate ? rsr_pkg::RSR_RATE_250K :
                    (high_rate ? rsr_pkg::RSR_RATE_2M : rsr_pkg::RSR_RATE_1M); // see RL9
  assign output_power = rf_q[`RSR_POWER_LSB +: 2]; // see RL10
endmodule // rsr_setup_regs
`default_nettype wire

// ==== tb/rsr_engine_model.sv ====
// Packet engine stand-in: ends a transmission, then reports the acknowledge.
`timescale 1ns/1ps
`default_nettype none
module rsr_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Trigger and mode
  input wire logic go,
  input wire logic fail_mode,
  // Engine events
  output logic tx_end,
  output logic ack_ok,
  output logic ack_fail
);
  logic [2:0] cnt_q;
  // The end of a transmission always comes before its acknowledge result.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 3'h0;
      tx_end <= 1'b0;
      ack_ok <= 1'b0;
      ack_fail <= 1'b0;
    end else begin
      tx_end <= cnt_q == 3'h3;
      ack_fail <= fail_mode && cnt_q == 3'h1;
      ack_ok <= !fail_mode && cnt_q == 3'h1;
      cnt_q <= go ? 3'h4 : cnt_q - 3'(cnt_q != 3'h0);
    end
  end
endmodule // rsr_engine_model
`default_nettype wire

// ==== tb/rsr_setup_regs_chk.sv ====
// Port checker for the radio setup register bank.
`timescale 1ns/1ps
`default_nettype none
module rsr_setup_regs_chk #(
  parameter int STEP_CYCLES = 4
) (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  // Results
  input wire logic [2:0] addr_bytes,
  input wire logic addr_width_illegal,
  input wire logic retry_start,
  input wire logic retry_wait,
  input wire logic retry_exhausted,
  input wire logic [3:0] lost_packet_counter,
  input wire logic [6:0] channel,
  input wire logic continuous_carrier,
  input wire logic pll_lock_force,
  input wire rsr_pkg::rsr_rate_type air_rate,
  input wire logic [1:0] output_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic wr_aw = clk_en && reg_wr && reg_addr == 5'h03;
  wire logic wr_ch = clk_en && reg_wr && reg_addr == 5'h05;
  wire logic wr_rf = clk_en && reg_wr && reg_addr == 5'h06;
  chan_write_a: assert property (wr_ch |=> channel == $past(reg_wdata[6:0]) && lost_packet_counter == 4'h0)
    else $error("channel write not applied");
  rf_write_a: assert property (wr_rf |=> {continuous_carrier, pll_lock_force, output_power} ==
    {$past(reg_wdata[7]), $past(reg_wdata[4]), $past(reg_wdata[2:1])}) else $error("radio setup fields wrong");
  rate_map_a: assert property (wr_rf |=> air_rate == ($past(reg_wdata[5]) ? rsr_pkg::RSR_RATE_250K :
    $past(reg_wdata[3]) ? rsr_pkg::RSR_RATE_2M : rsr_pkg::RSR_RATE_1M)) else $error("air rate wrong");
  width_bytes_a: assert property (wr_aw ##1 clk_en |=> addr_bytes == ($past(reg_wdata[1:0], 2) == 2'h1 ? 3'h3 :
    $past(reg_wdata[1:0], 2) == 2'h2 ? 3'h4 : 3'h5)) else $error("address width wrong");
  width_flag_a: assert property (wr_aw |=> addr_width_illegal == ($past(reg_wdata[1:0]) == 2'h0))
    else $error("illegal width flag wrong");
  read_ch_a: assert property (clk_en && reg_rd && !reg_wr && reg_addr == 5'h05 |=> reg_rdata == {1'b0, channel})
    else $error("channel readback wrong");
  unmapped_read_a: assert property (clk_en && reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  hit_decode_a: assert property (reg_hit == (reg_addr >= 5'h03 && reg_addr <= 5'h06))
    else $error("address decode wrong");
  start_pulse_a: assert property (retry_start |-> $past(retry_wait) ##1 !retry_start)
    else $error("retry start malformed");
  exhaust_pulse_a: assert property (retry_exhausted |=> !retry_exhausted)
    else $error("exhausted pulse too long");
  cover property (retry_start);
  cover property (retry_exhausted);
  cover property (wr_ch ##1 channel == 7'h7F);
endmodule // rsr_setup_regs_chk
bind rsr_setup_regs rsr_setup_regs_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.clk, .reset_n, .clk_en, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .addr_bytes, .addr_width_illegal, .retry_start,
  .retry_wait, .retry_exhausted, .lost_packet_counter, .channel, .continuous_carrier, .pll_lock_force,
  .air_rate, .output_power);
`default_nettype wire

// ==== tb/test_rsr_setup_regs.sv ====
// Self-checking bench for the radio setup register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: got %h", $time, a); end end
module test_rsr_setup_regs;
  logic clk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, go = 0, fail_mode = 1;
  logic [4:0] reg_addr = 0, addr_byte_en;
  logic [7:0] reg_wdata = 0, reg_rdata, got;
  logic reg_hit, tx_end, ack_ok, ack_fail, retry_start, retry_wait, retry_exhausted;
  logic continuous_carrier, pll_lock_force, addr_width_illegal;
  logic [2:0] addr_bytes;
  logic [3:0] retry_used, lost_packet_counter;
  logic [6:0] channel;
  logic [1:0] output_power;
  rsr_pkg::rsr_rate_type air_rate;
  int n_fail = 0, tests_run = 0, n;
  logic [7:0] rst_vals [4] = '{8'h03, 8'h03, 8'h02, 8'h0E};
  logic [8:0] width_exp [4] = '{9'h17F, 9'h0CE, 9'h11E, 9'h17E};
  // Offset, written value, value read back; reserved bits and unmapped places read zero.
  logic [20:0] rows [9] = '{{5'h03, 8'hFF, 8'h03}, {5'h03, 8'h01, 8'h01}, {5'h04, 8'hF5, 8'hF5},
    {5'h05, 8'hFF, 8'h7F}, {5'h06, 8'hFF, 8'hBE}, {5'h06, 8'h41, 8'h00}, {5'h02, 8'h55, 8'h00},
    {5'h1F, 8'hAA, 8'h00}, {5'h05, 8'h15, 8'h15}};
  rsr_setup_regs #(.STEP_CYCLES(4)) u_dut (.clk, .reset_n, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_hit, .tx_end, .ack_ok, .ack_fail, .addr_bytes, .addr_byte_en, .addr_width_illegal,
    .retry_start, .retry_wait, .retry_exhausted, .retry_used, .lost_packet_counter, .channel,
    .continuous_carrier, .pll_lock_force, .air_rate, .output_power);
  rsr_engine_model u_eng (.clk, .reset_n, .go(go | retry_start), .fail_mode, .tx_end, .ack_ok, .ack_fail);
  initial forever #12.5 clk = ~clk;
  task automatic end_sim();
    $display("Counts: %0d compared, %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // The host reaches the bank only through single register writes and reads.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 0;
    #1 got = reg_rdata;
  endtask
  task automatic kick();
    @(posedge clk) go <= 1;
    @(posedge clk) go <= 0;
  endtask
  task automatic wait_hi(input int s);
    for (n = 1; n < 300; n++) begin
      @(posedge clk) #1;
      if ((s == 0 ? retry_start : s == 1 ? retry_exhausted : s == 2 ? ack_fail : ack_ok) === 1'b1) return;
    end
    n_fail++;
    $display("Error at %0t: wait ran out", $time);
    end_sim();
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(5'(3 + i));
      `CHK(got, rst_vals[i])
    end
    `CHK({channel, output_power, air_rate, addr_bytes}, {7'h02, 2'h3, rsr_pkg::RSR_RATE_2M, 3'h5})
    $display("Test reset done");
    foreach (rows[i]) begin
      wr(rows[i][20:16], rows[i][15:8]);
      rd(rows[i][20:16]);
      `CHK(got, rows[i][7:0])
    end
    $display("Test table done");
    for (int i = 0; i < 4; i++) begin
      wr(5'h06, {2'h0, i[1], 1'b0, i[0], 3'h6});
      @(posedge clk) #1;
      `CHK(air_rate, i[1] ? rsr_pkg::RSR_RATE_250K : i[0] ? rsr_pkg::RSR_RATE_2M : rsr_pkg::RSR_RATE_1M)
    end
    $display("Test rate done");
    for (int i = 0; i < 4; i++) begin
      wr(5'h03, 8'(i));
      repeat (2) @(posedge clk);
      #1 `CHK({addr_bytes, addr_byte_en, addr_width_illegal}, width_exp[i])
    end
    $display("Test width done");
    // Delay code 1 with four-cycle steps waits eight cycles; count 2 allows two retries.
    wr(5'h04, 8'h12);
    kick();
    wait_hi(2);
    wait_hi(0);
    `CHK(n >= 9 && n <= 12, 1'b1)
    wait_hi(0);
    wait_hi(1);
    `CHK(n < 12, 1'b1)
    `CHK(retry_used, 4'h2)
    @(posedge clk) #1 `CHK(lost_packet_counter, 4'h1)
    wr(5'h04, 8'h00);
    kick();
    wait_hi(1);
    `CHK(n < 12, 1'b1)
    @(posedge clk) #1 `CHK(lost_packet_counter, 4'h2)
    wr(5'h05, 8'h20);
    @(posedge clk) #1 `CHK(lost_packet_counter, 4'h0)
    // One retry, then a good acknowledge clears the retry count.
    wr(5'h04, 8'h12);
    kick();
    wait_hi(0);
    @(posedge clk) fail_mode <= 0;
    wait_hi(3);
    `CHK(retry_used, 4'h1)
    @(posedge clk) #1 `CHK({retry_used, lost_packet_counter}, 8'h00)
    $display("Test retry done");
    @(posedge clk) clk_en <= 0;
    wr(5'h05, 8'h33);
    @(posedge clk) #1 `CHK(channel, 7'h20)
    @(posedge clk) clk_en <= 1;
    $display("Test freeze done");
    @(posedge clk) reset_n <= 0;
    repeat (2) @(posedge clk);
    reset_n <= 1;
    rd(5'h05);
    `CHK({got, lost_packet_counter}, {8'h02, 4'h0})
    $display("Test reset again done");
    end_sim();
  end
endmodule // test_rsr_setup_regs
`default_nettype wire
